// ### include/autoreload_pwm_pkg.sv
package autoreload_pwm_pkg;
	// Register indices, byte address is four times the index
	localparam logic [5:0] IDX_TIMER_CSR = 6'h0D;
	localparam logic [5:0] IDX_COUNTER_HIGH = 6'h0E;
	localparam logic [5:0] IDX_COUNTER_LOW = 6'h0F;
	localparam logic [5:0] IDX_RELOAD_HIGH = 6'h10;
	localparam logic [5:0] IDX_RELOAD_LOW = 6'h11;
	localparam logic [5:0] IDX_OUTPUT_CONTROL = 6'h12;
	localparam logic [5:0] IDX_CHANNEL_CSR0 = 6'h13;
	localparam logic [5:0] IDX_DUTY_HIGH0 = 6'h17;
	localparam logic [5:0] IDX_CAPTURE_HIGH = 6'h1F;
	localparam logic [5:0] IDX_CAPTURE_LOW = 6'h20;
	localparam logic [5:0] IDX_TRANSFER = 6'h21;
	localparam logic [5:0] IDX_BREAK_CONTROL = 6'h22;

	// Timer status/control fields
	localparam int CSR_CAPTURE_FLAG = 6;
	localparam int CSR_CAPTURE_IRQ_EN = 5;
	localparam int CSR_CLK_SEL_HI = 4;
	localparam int CSR_CLK_SEL_LO = 3;
	localparam int CSR_OVERFLOW_FLAG = 2;
	localparam int CSR_OVERFLOW_IRQ_EN = 1;
	localparam int CSR_COMPARE_IRQ_EN = 0;
	// Channel status fields
	localparam int CH_POLARITY = 1;
	localparam int CH_COMPARE_FLAG = 0;
	// Break control fields
	localparam int BRK_ACTIVE = 5;
	localparam int BRK_PIN_EN = 4;

	localparam int COUNT_W = 12;
	localparam int NUM_CH = 4;
	localparam logic [11:0] COUNT_TOP = 12'hFFF;
	localparam logic [11:0] COUNT_RESET = 12'h000;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic TRANSFER_RESET = 1'b1;
	localparam int SLOW_DIVIDE = 32;

	typedef enum logic [1:0] {
		CLK_OFF = 2'b00,
		CLK_LITE = 2'b01,
		CLK_CPU = 2'b10,
		CLK_FAST = 2'b11
	} clk_sel_t;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : autoreload_pwm_pkg

// ### hdl/autoreload_pwm_timer.sv
`timescale 1ns/1ns
// Summary of operation
// - Slow mode divides counter clock by SLOW_DIV, 32 by default.
// - Active-halt stops counter except timebase with overflow irq.
// - Wait has no effect; halt stops counter.
// - Wake outputs per mode: wait on any interrupt, active-halt on overflow with lite clock only.
// - Capture/compare share one request; overflow separate.
// - Capture flag set by hardware, cleared by capture read.
// - Capture enable gates capture request.
// - Clock select applies after next overflow, or at once while clock is off.
// - Overflow flag set at wrap, cleared by status read.
// - Overflow enable gates overflow request.
// - Compare enable gates compare request.
// - Read-only 12-bit counter, upper bits zero.
// - Counter restarts from reload value.
// - Reload register sets common period.
// - Output enables hand pins to PWM.
// - Polarity bit inverts channel output.
// - Compare flag set on match, cleared by read.
// - Break bit set by enabled low pin or software.
// - Break pattern forced onto outputs during break.
// - Duty value sets duty or compare value.
// - Overflow raises outputs; match drops them.
// - Break clears counter, reload, duty, output control.
// - Capture latches counter on edges unless flag set.
// - Transfer bit enables shadow load, then clears.
module autoreload_pwm_timer #(
	parameter int SLOW_DIV = autoreload_pwm_pkg::SLOW_DIVIDE
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic liteTick,
	input wire logic fastTick,
	input wire logic slowMode,
	input wire logic activeHaltMode,
	input wire logic haltMode,
	input wire logic breakPinN,
	input wire logic capturePin,
	output logic [3:0] pwmOut,
	output logic [3:0] pwmDrive,
	output logic overflowIrq,
	output logic captureCompareIrq,
	output logic wakeFromWait,
	output logic wakeFromActiveHalt
);
	localparam int N = autoreload_pwm_pkg::NUM_CH;
	localparam logic [4:0] SLOW_LAST = 5'(SLOW_DIV - 1);

	if (SLOW_DIV < 2 || SLOW_DIV > 32) begin : gen_bad_div
		$error("SLOW_DIV must lie in 2..32");
	end

	// Bus slave state
	logic awHeld_q, wHeld_q, bValid_q, rValid_q;
	logic [5:0] awIdx_q;
	logic [7:0] wData_q;
	logic wLane_q;
	logic [1:0] bResp_q, rResp_q;
	logic [31:0] rData_q;
	logic wrEn, rdEn, wrHit, rdHit;
	logic [5:0] rdIdx;
	logic [7:0] rdByte;

	// Timer state
	logic [11:0] count_q, reload_q, captureValue_q;
	logic [1:0] clkSelSw_q;
	autoreload_pwm_pkg::clk_sel_t clkSelActive_q;
	logic captureFlag_q, captureIrqEn_q, overflowFlag_q, overflowIrqEn_q, compareIrqEn_q;
	logic [3:0] outEnable_q, breakPattern_q;
	logic breakActive_q, breakPinEn_q, transfer_q;
	logic [4:0] slowCnt_q;
	logic [2:0] capSync_q;
	logic [1:0] brkSync_q;
	logic baseTick, running, advance, overflow, captureEdge, captureRead;
	logic [N-1:0] compareFlag, polarity, polShadow, level;
	logic [11:0] duty [N];
	logic [11:0] dutyShadow [N];

	assign wrEn = awHeld_q && wHeld_q && !bValid_q;
	assign rdEn = s_axi_arvalid && !rValid_q;
	assign rdIdx = s_axi_araddr[7:2];
	assign s_axi_awready = !awHeld_q && !bValid_q;
	assign s_axi_wready = !wHeld_q && !bValid_q;
	assign s_axi_arready = !rValid_q;
	assign s_axi_bvalid = bValid_q;
	assign s_axi_bresp = bResp_q;
	assign s_axi_rvalid = rValid_q;
	assign s_axi_rresp = rResp_q;
	assign s_axi_rdata = rData_q;

	function automatic logic mapped(input logic [5:0] idx);
		mapped = idx >= autoreload_pwm_pkg::IDX_TIMER_CSR
			&& idx <= autoreload_pwm_pkg::IDX_BREAK_CONTROL;
	endfunction : mapped

	assign wrHit = mapped(awIdx_q) && wLane_q;
	assign rdHit = mapped(rdIdx);

	// Address and data taken in either order
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			awHeld_q <= 1'b0;
			awIdx_q <= 6'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			awHeld_q <= 1'b1;
			awIdx_q <= s_axi_awaddr[7:2];
		end else if (wrEn) begin
			awHeld_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wHeld_q <= 1'b0;
			wData_q <= 8'h00;
			wLane_q <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wHeld_q <= 1'b1;
			wData_q <= s_axi_wdata[7:0];
			wLane_q <= s_axi_wstrb[0];
		end else if (wrEn) begin
			wHeld_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			bValid_q <= 1'b0;
			bResp_q <= autoreload_pwm_pkg::RESP_OKAY;
		end else if (wrEn) begin
			bValid_q <= 1'b1;
			bResp_q <= mapped(awIdx_q) ? autoreload_pwm_pkg::RESP_OKAY
				: autoreload_pwm_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bValid_q <= 1'b0;
		end
	end

	// Read mux
	always_comb begin
		rdByte = 8'h00;
		unique case (rdIdx)
			autoreload_pwm_pkg::IDX_TIMER_CSR: begin
				rdByte = {1'b0, captureFlag_q, captureIrqEn_q, clkSelSw_q,
					overflowFlag_q, overflowIrqEn_q, compareIrqEn_q};
			end
			autoreload_pwm_pkg::IDX_COUNTER_HIGH: rdByte = {4'h0, count_q[11:8]};
			autoreload_pwm_pkg::IDX_COUNTER_LOW: rdByte = count_q[7:0];
			autoreload_pwm_pkg::IDX_RELOAD_HIGH: rdByte = {4'h0, reload_q[11:8]};
			autoreload_pwm_pkg::IDX_RELOAD_LOW: rdByte = reload_q[7:0];
			autoreload_pwm_pkg::IDX_OUTPUT_CONTROL: begin
				rdByte = {1'b0, outEnable_q[3], 1'b0, outEnable_q[2],
					1'b0, outEnable_q[1], 1'b0, outEnable_q[0]};
			end
			autoreload_pwm_pkg::IDX_CAPTURE_HIGH: rdByte = {4'h0, captureValue_q[11:8]};
			autoreload_pwm_pkg::IDX_CAPTURE_LOW: rdByte = captureValue_q[7:0];
			autoreload_pwm_pkg::IDX_TRANSFER: rdByte = {7'h00, transfer_q};
			autoreload_pwm_pkg::IDX_BREAK_CONTROL: begin
				rdByte = {2'b00, breakActive_q, breakPinEn_q, breakPattern_q};
			end
			default: begin
				for (int c = 0; c < N; c++) begin
					if (rdIdx == autoreload_pwm_pkg::IDX_CHANNEL_CSR0 + 6'(c)) begin
						rdByte = {6'h00, polarity[c], compareFlag[c]};
					end
					if (rdIdx == autoreload_pwm_pkg::IDX_DUTY_HIGH0 + 6'(2 * c)) begin
						rdByte = {4'h0, duty[c][11:8]};
					end
					if (rdIdx == autoreload_pwm_pkg::IDX_DUTY_HIGH0 + 6'(2 * c + 1)) begin
						rdByte = duty[c][7:0];
					end
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rValid_q <= 1'b0;
			rData_q <= 32'h0000_0000;
			rResp_q <= autoreload_pwm_pkg::RESP_OKAY;
		end else if (rdEn) begin
			rValid_q <= 1'b1;
			rData_q <= {24'h000000, rdByte};
			rResp_q <= rdHit ? autoreload_pwm_pkg::RESP_OKAY : autoreload_pwm_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			rValid_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			capSync_q <= 3'b000;
			brkSync_q <= 2'b11;
		end else begin
			capSync_q <= {capSync_q[1:0], capturePin};
			brkSync_q <= {brkSync_q[0], breakPinN};
		end
	end

	always_comb begin
		unique case (clkSelActive_q)
			autoreload_pwm_pkg::CLK_OFF: baseTick = 1'b0;
			autoreload_pwm_pkg::CLK_LITE: baseTick = liteTick;
			autoreload_pwm_pkg::CLK_CPU: baseTick = 1'b1;
			autoreload_pwm_pkg::CLK_FAST: baseTick = fastTick;
		endcase
	end

	assign running = !haltMode && !(activeHaltMode
		&& !(clkSelActive_q == autoreload_pwm_pkg::CLK_LITE && overflowIrqEn_q));
	assign advance = baseTick && running && !breakActive_q
		&& (!slowMode || slowCnt_q == SLOW_LAST);
	assign overflow = advance && count_q == autoreload_pwm_pkg::COUNT_TOP;

	always_ff @(posedge ref_clk) begin
		if (rst || !slowMode) begin
			slowCnt_q <= 5'h00;
		end else if (baseTick && running) begin
			slowCnt_q <= (slowCnt_q == SLOW_LAST) ? 5'h00 : slowCnt_q + 5'h01;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst || breakActive_q) begin
			count_q <= autoreload_pwm_pkg::COUNT_RESET;
		end else if (overflow) begin
			count_q <= reload_q;
		end else if (advance) begin
			count_q <= count_q + 12'h001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst || breakActive_q) begin
			reload_q <= autoreload_pwm_pkg::COUNT_RESET;
		end else if (wrEn && wrHit && awIdx_q == autoreload_pwm_pkg::IDX_RELOAD_HIGH) begin
			reload_q[11:8] <= wData_q[3:0];
		end else if (wrEn && wrHit && awIdx_q == autoreload_pwm_pkg::IDX_RELOAD_LOW) begin
			reload_q[7:0] <= wData_q;
		end
	end

	// Status/control register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			captureIrqEn_q <= 1'b0;
			clkSelSw_q <= 2'b00;
			overflowIrqEn_q <= 1'b0;
			compareIrqEn_q <= 1'b0;
		end else if (wrEn && wrHit && awIdx_q == autoreload_pwm_pkg::IDX_TIMER_CSR) begin
			captureIrqEn_q <= wData_q[autoreload_pwm_pkg::CSR_CAPTURE_IRQ_EN];
			clkSelSw_q <= {wData_q[autoreload_pwm_pkg::CSR_CLK_SEL_HI],
				wData_q[autoreload_pwm_pkg::CSR_CLK_SEL_LO]};
			overflowIrqEn_q <= wData_q[autoreload_pwm_pkg::CSR_OVERFLOW_IRQ_EN];
			compareIrqEn_q <= wData_q[autoreload_pwm_pkg::CSR_COMPARE_IRQ_EN];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			clkSelActive_q <= autoreload_pwm_pkg::CLK_OFF;
		end else if (overflow || clkSelActive_q == autoreload_pwm_pkg::CLK_OFF) begin
			clkSelActive_q <= autoreload_pwm_pkg::clk_sel_t'(clkSelSw_q);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			overflowFlag_q <= 1'b0;
		end else if (overflow) begin
			overflowFlag_q <= 1'b1;
		end else if (rdEn && rdIdx == autoreload_pwm_pkg::IDX_TIMER_CSR) begin
			overflowFlag_q <= 1'b0;
		end
	end

	assign captureEdge = capSync_q[2] != capSync_q[1];
	assign captureRead = rdEn && (rdIdx == autoreload_pwm_pkg::IDX_CAPTURE_HIGH
		|| rdIdx == autoreload_pwm_pkg::IDX_CAPTURE_LOW);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			captureValue_q <= autoreload_pwm_pkg::COUNT_RESET;
		end else if (captureEdge && !captureFlag_q) begin
			captureValue_q <= count_q;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			captureFlag_q <= 1'b0;
		end else if (captureEdge && !captureFlag_q) begin
			captureFlag_q <= 1'b1;
		end else if (captureRead) begin
			captureFlag_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst || breakActive_q) begin
			outEnable_q <= 4'h0;
		end else if (wrEn && wrHit && awIdx_q == autoreload_pwm_pkg::IDX_OUTPUT_CONTROL) begin
			outEnable_q <= {wData_q[6], wData_q[4], wData_q[2], wData_q[0]};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			transfer_q <= autoreload_pwm_pkg::TRANSFER_RESET;
		end else if (wrEn && wrHit && awIdx_q == autoreload_pwm_pkg::IDX_TRANSFER) begin
			transfer_q <= wData_q[0];
		end else if (overflow && transfer_q) begin
			transfer_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			breakActive_q <= 1'b0;
			breakPinEn_q <= 1'b0;
			breakPattern_q <= 4'h0;
		end else begin
			if (wrEn && wrHit && awIdx_q == autoreload_pwm_pkg::IDX_BREAK_CONTROL) begin
				breakPinEn_q <= wData_q[autoreload_pwm_pkg::BRK_PIN_EN];
				breakPattern_q <= wData_q[3:0];
			end
			if (breakPinEn_q && !brkSync_q[1]) begin
				breakActive_q <= 1'b1;
			end else if (wrEn && wrHit
				&& awIdx_q == autoreload_pwm_pkg::IDX_BREAK_CONTROL) begin
				breakActive_q <= wData_q[autoreload_pwm_pkg::BRK_ACTIVE];
			end
		end
	end

	// Per-channel logic
	for (genvar c = 0; c < N; c++) begin : gen_ch
		localparam logic [5:0] CSR_IDX = autoreload_pwm_pkg::IDX_CHANNEL_CSR0 + 6'(c);
		localparam logic [5:0] HI_IDX = autoreload_pwm_pkg::IDX_DUTY_HIGH0 + 6'(2 * c);
		localparam logic [5:0] LO_IDX = autoreload_pwm_pkg::IDX_DUTY_HIGH0 + 6'(2 * c + 1);
		logic match;

		assign match = advance && !overflow && count_q + 12'h001 == dutyShadow[c]
			&& dutyShadow[c] != 12'h000;

		always_ff @(posedge ref_clk) begin
			if (rst || breakActive_q) begin
				duty[c] <= autoreload_pwm_pkg::COUNT_RESET;
			end else if (wrEn && wrHit && awIdx_q == HI_IDX) begin
				duty[c][11:8] <= wData_q[3:0];
			end else if (wrEn && wrHit && awIdx_q == LO_IDX) begin
				duty[c][7:0] <= wData_q;
			end
		end

		always_ff @(posedge ref_clk) begin
			if (rst) begin
				polarity[c] <= 1'b0;
			end else if (wrEn && wrHit && awIdx_q == CSR_IDX) begin
				polarity[c] <= wData_q[autoreload_pwm_pkg::CH_POLARITY];
			end
		end

		always_ff @(posedge ref_clk) begin
			if (rst || breakActive_q) begin
				dutyShadow[c] <= autoreload_pwm_pkg::COUNT_RESET;
				polShadow[c] <= 1'b0;
			end else if (overflow && transfer_q) begin
				dutyShadow[c] <= duty[c];
				polShadow[c] <= polarity[c];
			end
		end

		always_ff @(posedge ref_clk) begin
			if (rst) begin
				compareFlag[c] <= 1'b0;
			end else if (match) begin
				compareFlag[c] <= 1'b1;
			end else if (rdEn && rdIdx == CSR_IDX) begin
				compareFlag[c] <= 1'b0;
			end
		end

		// high at overflow, low at match
		always_ff @(posedge ref_clk) begin
			if (rst || breakActive_q) begin
				level[c] <= 1'b0;
			end else if (overflow) begin
				level[c] <= 1'b1;
			end else if (match) begin
				level[c] <= 1'b0;
			end
		end

		always_ff @(posedge ref_clk) begin
			if (rst) begin
				pwmOut[c] <= 1'b0;
			end else begin
				pwmOut[c] <= breakActive_q ? breakPattern_q[c] : (level[c] ^ polShadow[c]);
			end
		end

		assign pwmDrive[c] = outEnable_q[c] || breakActive_q;
	end

	assign overflowIrq = overflowFlag_q && overflowIrqEn_q;
	assign captureCompareIrq = (captureFlag_q && captureIrqEn_q)
		|| (|compareFlag && compareIrqEn_q);
	assign wakeFromWait = overflowIrq || captureCompareIrq;
	assign wakeFromActiveHalt = overflowIrq && clkSelActive_q == autoreload_pwm_pkg::CLK_LITE;
endmodule : autoreload_pwm_timer

// ### tb/autoreload_pwm_far_side.sv
`timescale 1ns/1ns
module autoreload_pwm_far_side (
	input wire logic ref_clk,
	input wire logic capReq,
	input wire logic breakReq,
	input wire logic [3:0] pwmOut,
	output logic capturePin,
	output logic breakPinN,
	output logic [7:0] hiCnt
);
	logic [7:0] runCnt;
	initial begin
		capturePin = 1'b0;
		breakPinN = 1'b1;
		runCnt = 8'h00;
		hiCnt = 8'h00;
	end
	always @(posedge ref_clk) if (capReq) capturePin <= !capturePin;
	always @(posedge ref_clk) breakPinN <= !breakReq;
	// Width of last high pulse
	always @(posedge ref_clk) begin
		runCnt <= pwmOut[0] ? runCnt + 8'h01 : 8'h00;
		if (!pwmOut[0] && runCnt != 8'h00) hiCnt <= runCnt;
	end
endmodule : autoreload_pwm_far_side

// ### tb/autoreload_pwm_checker.sv
`timescale 1ns/1ns
module autoreload_pwm_checker #(
	parameter int SLOW_DIV = 32
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic breakPinN,
	input wire logic [3:0] pwmDrive,
	input wire logic overflowIrq,
	input wire logic captureCompareIrq,
	input wire logic wakeFromWait,
	input wire logic wakeFromActiveHalt
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence s_ar_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_w_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_bad_addr;
		s_axi_awvalid && s_axi_awready && s_axi_awaddr[7:2] > 6'h22;
	endsequence
	sequence s_slverr;
		s_axi_bvalid && s_axi_bresp == autoreload_pwm_pkg::RESP_SLVERR;
	endsequence
	property p_wake_wait;
		wakeFromWait == (overflowIrq || captureCompareIrq);
	endproperty
	a_wake_wait: assert property (p_wake_wait) else $error("wait wake differs");
	property p_wake_halt;
		wakeFromActiveHalt |-> overflowIrq;
	endproperty
	a_wake_halt: assert property (p_wake_halt) else $error("halt wake without overflow");
	property p_rdata_hi;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
	endproperty
	a_rdata_hi: assert property (p_rdata_hi) else $error("upper read bits set");
	property p_ar_ans;
		s_ar_take |=> s_axi_rvalid;
	endproperty
	a_ar_ans: assert property (p_ar_ans) else $error("read answer late");
	property p_ar_ready;
		s_axi_arready == !s_axi_rvalid;
	endproperty
	a_ar_ready: assert property (p_ar_ready) else $error("arready wrong");
	property p_b_ans;
		s_w_take |-> ##2 s_axi_bvalid;
	endproperty
	a_b_ans: assert property (p_b_ans) else $error("write answer late");
	property p_r_once;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty
	a_r_once: assert property (p_r_once) else $error("read answer repeated");
	property p_unmapped;
		s_bad_addr |-> ##[1:4] s_slverr;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("no error response");
	property p_pin_sync;
		$fell(breakPinN) && s_axi_awready && !s_axi_awvalid |=> $stable(pwmDrive);
	endproperty
	a_pin_sync: assert property (p_pin_sync) else $error("break pin not synchronised");
endmodule : autoreload_pwm_checker
bind autoreload_pwm_timer autoreload_pwm_checker #(.SLOW_DIV(SLOW_DIV)) u_checker (
	.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .breakPinN, .pwmDrive, .overflowIrq,
	.captureCompareIrq, .wakeFromWait, .wakeFromActiveHalt
);

// ### tb/autoreload_pwm_timer_12bit_tb_top.sv
`timescale 1ns/1ns
module autoreload_pwm_timer_12bit_tb_top;
	logic ref_clk;
	logic rst;
	logic [7:0] s_axi_awaddr, s_axi_araddr, hiCnt, d;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, pwmOut, pwmDrive;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic liteTick, fastTick, slowMode, activeHaltMode, haltMode, breakPinN, capturePin;
	logic overflowIrq, captureCompareIrq, wakeFromWait, wakeFromActiveHalt, capReq, breakReq;
	logic [2:0] tickCnt;
	int n_fail, comparisons;
	autoreload_pwm_timer #(.SLOW_DIV(4)) DUT (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .liteTick, .fastTick,
		.slowMode, .activeHaltMode, .haltMode, .breakPinN, .capturePin, .pwmOut, .pwmDrive,
		.overflowIrq, .captureCompareIrq, .wakeFromWait, .wakeFromActiveHalt);
	autoreload_pwm_far_side u_far (.ref_clk, .capReq, .breakReq, .pwmOut, .capturePin,
		.breakPinN, .hiCnt);
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = !ref_clk;
	end
	always @(posedge ref_clk) begin
		tickCnt <= tickCnt + 3'h1;
		liteTick <= (tickCnt == 3'h7);
		fastTick <= tickCnt[0];
	end
	task automatic conclude;
		if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : conclude
	task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : cmp_byte
	task automatic cmp_nib(input logic [3:0] g, input logic [3:0] e);
		cmp_byte({4'h0, g}, {4'h0, e});
	endtask : cmp_nib
	task automatic cmp_bit(input logic g, input logic e);
		cmp_byte({7'h00, g}, {7'h00, e});
	endtask : cmp_bit
	task automatic tick(input int k);
		repeat (k) @(posedge ref_clk);
	endtask : tick
	task automatic wr(input logic [5:0] i, input logic [7:0] v);
		int n;
		n = 0;
		s_axi_awaddr <= {i, 2'b00};
		s_axi_wdata <= {24'h000000, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			n++;
		end while (s_axi_bvalid !== 1'b1 && n < 60);
		s_axi_bready <= 1'b0;
		r = s_axi_bresp;
		if (n == 60) begin
			n_fail++;
			conclude();
		end
		@(posedge ref_clk);
	endtask : wr
	task automatic rd(input logic [5:0] i);
		int n;
		n = 0;
		s_axi_araddr <= {i, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			n++;
		end while (s_axi_rvalid !== 1'b1 && n < 60);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata[7:0];
		r = s_axi_rresp;
		if (n == 60) begin
			n_fail++;
			conclude();
		end
		@(posedge ref_clk);
	endtask : rd
	task automatic t_reset;
		logic [5:0] idx [6] = '{6'h0D, 6'h0F, 6'h11, 6'h12, 6'h13, 6'h22};
		for (int k = 0; k < 6; k++) begin
			rd(idx[k]);
			cmp_byte(d, 8'h00);
		end
		rd(6'h21);
		cmp_byte(d, 8'h01);
		wr(6'h0F, 8'h55);
		rd(6'h0F);
		cmp_byte(d, 8'h00);
		wr(6'h30, 8'hA5);
		cmp_byte({6'h00, r}, {6'h00, autoreload_pwm_pkg::RESP_SLVERR});
		rd(6'h30);
		cmp_byte({6'h00, r}, {6'h00, autoreload_pwm_pkg::RESP_SLVERR});
	endtask : t_reset
	task automatic t_overflow;
		int n;
		wr(6'h10, 8'h0F);
		wr(6'h11, 8'hF0);
		wr(6'h0D, 8'h13);
		n = 0;
		while (overflowIrq !== 1'b1 && n < 5000) begin
			@(posedge ref_clk);
			n++;
		end
		if (n == 5000) begin
			n_fail++;
			conclude();
		end
		cmp_bit(wakeFromWait, 1'b1);
		cmp_bit(wakeFromActiveHalt, 1'b0);
		rd(6'h0D);
		cmp_byte(d, 8'h17);
		cmp_bit(overflowIrq, 1'b0);
		rd(6'h0F);
		cmp_nib(d[7:4], 4'hF);
		rd(6'h0E);
		cmp_byte(d, 8'h0F);
	endtask : t_overflow
	task automatic t_pwm;
		wr(6'h17, 8'h0F);
		wr(6'h18, 8'hFC);
		wr(6'h12, 8'h01);
		wr(6'h21, 8'h01);
		tick(40);
		cmp_byte(hiCnt, 8'h0C);
		cmp_nib(pwmDrive, 4'h1);
		cmp_bit(captureCompareIrq, 1'b1);
		rd(6'h13);
		cmp_byte(d, 8'h01);
		wr(6'h13, 8'h02);
		wr(6'h21, 8'h01);
		tick(40);
		cmp_byte(hiCnt, 8'h04);
		rd(6'h21);
		cmp_byte(d, 8'h00);
	endtask : t_pwm
	task automatic t_capture;
		wr(6'h0D, 8'h32);
		capReq <= 1'b1;
		@(posedge ref_clk);
		capReq <= 1'b0;
		tick(10);
		cmp_bit(captureCompareIrq, 1'b1);
		rd(6'h0D);
		cmp_byte(d & 8'h78, 8'h70);
		rd(6'h1F);
		cmp_byte(d, 8'h0F);
		cmp_bit(captureCompareIrq, 1'b0);
		wr(6'h0D, 8'h72);
		rd(6'h0D);
		cmp_byte(d & 8'h40, 8'h00);
	endtask : t_capture
	task automatic t_break;
		wr(6'h22, 8'h15);
		breakReq <= 1'b1;
		tick(10);
		rd(6'h22);
		cmp_byte(d, 8'h35);
		cmp_nib(pwmOut, 4'h5);
		cmp_nib(pwmDrive, 4'hF);
		rd(6'h12);
		cmp_byte(d, 8'h00);
		rd(6'h11);
		cmp_byte(d, 8'h00);
		breakReq <= 1'b0;
		tick(6);
		wr(6'h22, 8'h00);
		tick(2);
		cmp_nib(pwmDrive, 4'h0);
	endtask : t_break
	task automatic t_modes;
		logic [7:0] a;
		int n;
		haltMode <= 1'b1;
		tick(2);
		rd(6'h0F);
		a = d;
		tick(10);
		rd(6'h0F);
		cmp_byte(d, a);
		haltMode <= 1'b0;
		activeHaltMode <= 1'b1;
		tick(2);
		rd(6'h0F);
		a = d;
		tick(10);
		rd(6'h0F);
		cmp_byte(d, a);
		activeHaltMode <= 1'b0;
		slowMode <= 1'b1;
		tick(2);
		rd(6'h0F);
		a = d;
		tick(40);
		rd(6'h0F);
		a = d - a;
		cmp_bit(a >= 8'h0A && a <= 8'h0B, 1'b1);
		slowMode <= 1'b0;
		wr(6'h10, 8'h0F);
		wr(6'h11, 8'h00);
		wr(6'h0D, 8'h0A);
		n = 0;
		while (overflowIrq !== 1'b1 && n < 5000) begin
			@(posedge ref_clk);
			n++;
		end
		if (n == 5000) begin
			n_fail++;
			conclude();
		end
		cmp_bit(wakeFromActiveHalt, 1'b1);
		activeHaltMode <= 1'b1;
		rd(6'h0F);
		a = d;
		tick(40);
		rd(6'h0F);
		a = d - a;
		cmp_bit(a >= 8'h05 && a <= 8'h06, 1'b1);
	endtask : t_modes
	initial begin
		{rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h3F;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{slowMode, activeHaltMode, haltMode, capReq, breakReq} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'h1;
		tickCnt = 3'h0;
		{liteTick, fastTick} = 2'b00;
		n_fail = 0;
		comparisons = 0;
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		t_reset();
		t_overflow();
		t_pwm();
		t_capture();
		t_break();
		t_modes();
		conclude();
	end
endmodule : autoreload_pwm_timer_12bit_tb_top
